// File: core/mmio_pkg.sv
package mmio_pkg;

   // ************************************************************
   // register indices; each byte address is four times its index
   // ************************************************************
   localparam logic [15:0] IDX_CTL_DIR = 16'hFF81;
   localparam logic [15:0] IDX_CTL_DATA = 16'hFF83;
   localparam logic [15:0] IDX_DB_DIR = 16'hFF84;
   localparam logic [15:0] IDX_AL_DIR = 16'hFF85;
   localparam logic [15:0] IDX_DB_DATA = 16'hFF86;
   localparam logic [15:0] IDX_AL_DATA = 16'hFF87;
   localparam logic [15:0] IDX_MODE_STAT = 16'hFF88;

   localparam int ADR_W = 18;

   // ************************************************************
   // reset values and field layout
   // ************************************************************
   localparam logic [7:0] RST_CTL_DIR = 8'hE0;
   localparam logic [7:0] RST_CTL_DATA = 8'hE0;
   localparam logic [7:0] RST_DB_DIR = 8'h00;
   localparam logic [7:0] RST_AL_DIR = 8'h00;
   localparam logic [7:0] RST_DB_DATA = 8'h00;
   localparam logic [7:0] RST_AL_DATA = 8'h00;
   localparam logic [7:0] CTL_RSVD_MASK = 8'hE0;
   localparam logic [7:0] WO_READ = 8'hFF;
   localparam int CTL_PINS = 5;

   // ************************************************************
   // operating modes
   // ************************************************************
   localparam logic [2:0] MODE_EXP1 = 3'h1;
   localparam logic [2:0] MODE_EXP2 = 3'h2;
   localparam logic [2:0] MODE_EXP3 = 3'h3;
   localparam logic [2:0] MODE_EXP4 = 3'h4;
   localparam logic [2:0] MODE_SINGLE = 3'h7;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } mmio_bus_type;

   // strobes from the external bus controller
   typedef struct packed {
      logic address_strobe_n;
      logic read_write_n;
      logic data_strobe_n;
      logic read_n;
      logic write_n;
   } mmio_strobe_type;

   // one pin group: level to drive and its enable
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } mmio_pins_type;

endpackage

// File: core/mmio_ports.sv
`timescale 1ns/10ps

// Operation
// - single-chip: direction 1 drives the data bit, 0 makes an input.
// - modes 1 to 4 are expanded, mode 7 is single-chip.
// - control port direction bits 4..0 write-only; reads give all ones.
// - both eight-bit direction registers write-only; reads give all ones.
// - control port bits 7..5 ignore writes and read as one.
// - reset or hardware standby loads control direction with E0.
// - reset or hardware standby clears data-bus port direction.
// - reset or hardware standby clears address-byte port direction.
// - software standby leaves direction and outputs unchanged.
// - reset or hardware standby clears data-bus port data.
// - reset or hardware standby clears address-byte port data.
// - data read gives latch for outputs, pin level for inputs.
// - expanded: control direction forced to one, writes ignored.
// - expanded: control pins carry the five bus strobes.
// - expanded: data-bus port carries D7..D0, direction ignored.
// - expanded: address-byte port outputs A7..A0, forced to output.
// - expanded: address-byte direction fixed at one, writes ignored.
// - control port has exactly five pins at bits 4..0.
module mmio_ports (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // mode and standby
   input wire logic [2:0] MODE,
   input wire logic HW_STANDBY,
   input wire logic SW_STANDBY,
   // wishbone slave
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [3:0] WB_SEL,
   input wire logic [mmio_pkg::ADR_W-1:0] WB_ADR,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   output logic WB_ERR,
   // external bus controller
   input wire mmio_pkg::mmio_strobe_type BUS_STROBE,
   input wire logic [7:0] BUS_DATA_OUT,
   input wire logic BUS_DATA_DRIVE,
   input wire logic [7:0] BUS_ADDR_LOW,
   output logic [7:0] BUS_DATA_IN,
   // control port pins
   input wire logic [4:0] CTL_PIN_IN,
   output logic [4:0] CTL_PIN_OUT,
   output logic [4:0] CTL_PIN_OE,
   // data-bus port pins
   input wire logic [7:0] DB_PIN_IN,
   output logic [7:0] DB_PIN_OUT,
   output logic [7:0] DB_PIN_OE,
   // address-byte port pins
   input wire logic [7:0] AL_PIN_IN,
   output logic [7:0] AL_PIN_OUT,
   output logic [7:0] AL_PIN_OE
);

   // ************************************************************
   // mode decode
   // ************************************************************
   logic expanded;
   logic clear;
   always_comb begin
      expanded = (MODE == mmio_pkg::MODE_EXP1) ||
                 (MODE == mmio_pkg::MODE_EXP2) ||
                 (MODE == mmio_pkg::MODE_EXP3) ||
                 (MODE == mmio_pkg::MODE_EXP4);
      clear = HW_STANDBY;
   end

   // ************************************************************
   // bus decode
   // ************************************************************
   mmio_pkg::mmio_bus_type bus_state;
   logic req;
   logic lane0;
   logic [15:0] idx;
   logic hit;
   logic wr;
   always_comb begin
      req = WB_CYC && WB_STB && (bus_state == mmio_pkg::BUS_IDLE);
      lane0 = WB_SEL[0];
      idx = WB_ADR[17:2];
      hit = (WB_ADR[1:0] == 2'b00) &&
            ((idx == mmio_pkg::IDX_CTL_DIR) ||
             (idx == mmio_pkg::IDX_CTL_DATA) ||
             (idx == mmio_pkg::IDX_DB_DIR) ||
             (idx == mmio_pkg::IDX_AL_DIR) ||
             (idx == mmio_pkg::IDX_DB_DATA) ||
             (idx == mmio_pkg::IDX_AL_DATA) ||
             (idx == mmio_pkg::IDX_MODE_STAT));
      wr = req && hit && WB_WE && lane0;
   end

   // ************************************************************
   // port registers
   // ************************************************************
   logic [4:0] ctl_dir;
   logic [4:0] ctl_data;
   logic [7:0] db_dir;
   logic [7:0] db_data;
   logic [7:0] al_dir;
   logic [7:0] al_data;

   // software standby has no term here: state simply holds
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ctl_dir <= mmio_pkg::RST_CTL_DIR[4:0];
      end else if (clear) begin
         ctl_dir <= mmio_pkg::RST_CTL_DIR[4:0];
      end else if (wr && !expanded &&
                   idx == mmio_pkg::IDX_CTL_DIR) begin
         ctl_dir <= WB_DAT_I[4:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ctl_data <= mmio_pkg::RST_CTL_DATA[4:0];
      end else if (clear) begin
         ctl_data <= mmio_pkg::RST_CTL_DATA[4:0];
      end else if (wr && idx == mmio_pkg::IDX_CTL_DATA) begin
         ctl_data <= WB_DAT_I[4:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         db_dir <= mmio_pkg::RST_DB_DIR;
      end else if (clear) begin
         db_dir <= mmio_pkg::RST_DB_DIR;
      end else if (wr && idx == mmio_pkg::IDX_DB_DIR) begin
         db_dir <= WB_DAT_I[7:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         al_dir <= mmio_pkg::RST_AL_DIR;
      end else if (clear) begin
         al_dir <= mmio_pkg::RST_AL_DIR;
      end else if (wr && !expanded &&
                   idx == mmio_pkg::IDX_AL_DIR) begin
         al_dir <= WB_DAT_I[7:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         db_data <= mmio_pkg::RST_DB_DATA;
      end else if (clear) begin
         db_data <= mmio_pkg::RST_DB_DATA;
      end else if (wr && idx == mmio_pkg::IDX_DB_DATA) begin
         db_data <= WB_DAT_I[7:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         al_data <= mmio_pkg::RST_AL_DATA;
      end else if (clear) begin
         al_data <= mmio_pkg::RST_AL_DATA;
      end else if (wr && idx == mmio_pkg::IDX_AL_DATA) begin
         al_data <= WB_DAT_I[7:0];
      end
   end

   // ************************************************************
   // effective direction and pin values
   // ************************************************************
   logic [4:0] ctl_eff;
   logic [7:0] db_eff;
   logic [7:0] al_eff;
   logic [4:0] strobe_vec;
   logic [4:0] next_ctl_out;
   logic [7:0] next_db_out;
   logic [7:0] next_al_out;
   always_comb begin
      strobe_vec = BUS_STROBE;
      ctl_eff = expanded ? 5'h1F : ctl_dir;
      al_eff = expanded ? 8'hFF : al_dir;
      db_eff = expanded ? {8{BUS_DATA_DRIVE}} : db_dir;
      next_ctl_out = expanded ? strobe_vec : ctl_data;
      next_db_out = expanded ? BUS_DATA_OUT : db_data;
      next_al_out = expanded ? BUS_ADDR_LOW : al_data;
   end

   // outputs registered: pins lag the controls by one cycle
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CTL_PIN_OUT <= 5'h00;
         CTL_PIN_OE <= 5'h00;
         DB_PIN_OUT <= 8'h00;
         DB_PIN_OE <= 8'h00;
         AL_PIN_OUT <= 8'h00;
         AL_PIN_OE <= 8'h00;
         BUS_DATA_IN <= 8'h00;
      end else begin
         CTL_PIN_OUT <= next_ctl_out;
         CTL_PIN_OE <= ctl_eff;
         DB_PIN_OUT <= next_db_out;
         DB_PIN_OE <= db_eff;
         AL_PIN_OUT <= next_al_out;
         AL_PIN_OE <= al_eff;
         BUS_DATA_IN <= DB_PIN_IN;
      end
   end

   // ************************************************************
   // read mux
   // ************************************************************
   logic [7:0] ctl_rd;
   logic [7:0] db_rd;
   logic [7:0] al_rd;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_rd
         if (g < mmio_pkg::CTL_PINS) begin : g_ctl
            assign ctl_rd[g] = ctl_eff[g] ? ctl_data[g] : CTL_PIN_IN[g];
         end else begin : g_rsv
            assign ctl_rd[g] = 1'b1;
         end
         assign db_rd[g] = db_eff[g] ? db_data[g] : DB_PIN_IN[g];
         assign al_rd[g] = al_eff[g] ? al_data[g] : AL_PIN_IN[g];
      end
   endgenerate

   logic [7:0] next_rd;
   always_comb begin
      case (idx)
         mmio_pkg::IDX_CTL_DIR: next_rd = mmio_pkg::WO_READ;
         mmio_pkg::IDX_CTL_DATA: next_rd = ctl_rd;
         mmio_pkg::IDX_DB_DIR: next_rd = mmio_pkg::WO_READ;
         mmio_pkg::IDX_AL_DIR: next_rd = mmio_pkg::WO_READ;
         mmio_pkg::IDX_DB_DATA: next_rd = db_rd;
         mmio_pkg::IDX_AL_DATA: next_rd = al_rd;
         mmio_pkg::IDX_MODE_STAT: next_rd = {4'h0, expanded, MODE};
         default: next_rd = 8'h00;
      endcase
   end

   // ************************************************************
   // wishbone answer: one wait state, ack for one cycle
   // ************************************************************
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         bus_state <= mmio_pkg::BUS_IDLE;
         WB_ACK <= 1'b0;
         WB_ERR <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         case (bus_state)
            mmio_pkg::BUS_IDLE: begin
               if (req) begin
                  bus_state <= mmio_pkg::BUS_ACK;
                  WB_ACK <= hit;
                  WB_ERR <= !hit;
                  WB_DAT_O <= {24'h000000, next_rd};
               end
            end
            mmio_pkg::BUS_ACK: begin
               bus_state <= mmio_pkg::BUS_IDLE;
               WB_ACK <= 1'b0;
               WB_ERR <= 1'b0;
            end
            default: begin
               bus_state <= mmio_pkg::BUS_IDLE;
               WB_ACK <= 1'b0;
               WB_ERR <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_ctl_expanded_oe;
      @(posedge REF_CLK) disable iff (!NRST)
         expanded |=> (CTL_PIN_OE == 5'h1F);
   endproperty
   a_ctl_expanded_oe: assert property (p_ctl_expanded_oe)
      else $error("control pins not all driven in expanded mode");

   property p_al_expanded_out;
      @(posedge REF_CLK) disable iff (!NRST)
         expanded |=> (AL_PIN_OUT == $past(BUS_ADDR_LOW));
   endproperty
   a_al_expanded_out: assert property (p_al_expanded_out)
      else $error("address byte not forwarded");

   property p_single_db_oe;
      @(posedge REF_CLK) disable iff (!NRST)
         !expanded |=> (DB_PIN_OE == $past(db_dir));
   endproperty
   a_single_db_oe: assert property (p_single_db_oe)
      else $error("data-bus pin enable differs from direction");

   property p_hw_standby;
      @(posedge REF_CLK) disable iff (!NRST)
         HW_STANDBY |=> (db_dir == 8'h00 && al_data == 8'h00 &&
                         ctl_dir == 5'h00);
   endproperty
   a_hw_standby: assert property (p_hw_standby)
      else $error("hardware standby did not clear registers");

   sequence s_dir_read;
      req && hit && !WB_WE && (idx == mmio_pkg::IDX_DB_DIR ||
                               idx == mmio_pkg::IDX_AL_DIR ||
                               idx == mmio_pkg::IDX_CTL_DIR);
   endsequence
   property p_dir_read_ones;
      @(posedge REF_CLK) disable iff (!NRST)
         s_dir_read |=> WB_ACK && (WB_DAT_O[7:0] == 8'hFF);
   endproperty
   a_dir_read_ones: assert property (p_dir_read_ones)
      else $error("direction read not all ones");

   property p_ctl_rsvd;
      @(posedge REF_CLK) disable iff (!NRST)
         (req && !WB_WE && idx == mmio_pkg::IDX_CTL_DATA)
            |=> (WB_DAT_O[7:5] == 3'b111);
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd)
      else $error("reserved control bits not one");

   property p_sw_standby_hold;
      @(posedge REF_CLK) disable iff (!NRST)
         (SW_STANDBY && !HW_STANDBY && !wr) |=> $stable(al_dir);
   endproperty
   a_sw_standby_hold: assert property (p_sw_standby_hold)
      else $error("direction changed in software standby");

   property p_exp_al_dir_locked;
      @(posedge REF_CLK) disable iff (!NRST)
         (expanded && !HW_STANDBY) |=> $stable(al_dir);
   endproperty
   a_exp_al_dir_locked: assert property (p_exp_al_dir_locked)
      else $error("address-byte direction written in expanded mode");

   property p_ack_pulse;
      @(posedge REF_CLK) disable iff (!NRST)
         WB_ACK |=> !WB_ACK;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");

endmodule

// File: tb/mmio_pins_model.sv
`timescale 1ns/10ps

// ****
// outside world at the three ports
// ****
module mmio_pins_model (
   // driven side
   input wire logic [4:0] ctl_out,
   input wire logic [4:0] ctl_oe,
   input wire logic [7:0] db_out,
   input wire logic [7:0] db_oe,
   input wire logic [7:0] al_out,
   input wire logic [7:0] al_oe,
   // far-side level, reshuffled by the bench before each random write
   input wire logic [20:0] ext,
   // levels seen back at the inputs
   output logic [4:0] ctl_in,
   output logic [7:0] db_in,
   output logic [7:0] al_in
);
   // released bits never keep the last driven level
   assign ctl_in = (ctl_out & ctl_oe) | (ext[20:16] & ~ctl_oe);
   assign db_in = (db_out & db_oe) | (ext[15:8] & ~db_oe);
   assign al_in = (al_out & al_oe) | (ext[7:0] & ~al_oe);
endmodule

// File: tb/mmio_ports_bench.sv
`timescale 1ns/10ps

module mmio_ports_bench;
   // ****
   // signals
   // ****
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] mode = 3'h7;
   logic hw_sb = 1'b0;
   logic sw_sb = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [mmio_pkg::ADR_W-1:0] adr = '0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack, err;
   mmio_pkg::mmio_strobe_type strobe = '0;
   logic [7:0] dout = 8'h00;
   logic drive = 1'b0;
   logic [7:0] al = 8'h00;
   logic [7:0] din, db_in, db_out, db_oe, al_in, al_out, al_oe;
   logic [4:0] ctl_in, ctl_out, ctl_oe;
   logic [20:0] ext = 21'h0;
   logic [7:0] sh [6];
   logic [31:0] rd;
   logic rerr;
   integer seed = 32'h9C00E1FA;
   int err_total = 0;
   int cmp_count = 0;
   localparam logic [15:0] IDX [6] = '{mmio_pkg::IDX_CTL_DIR,
      mmio_pkg::IDX_CTL_DATA, mmio_pkg::IDX_DB_DIR, mmio_pkg::IDX_AL_DIR,
      mmio_pkg::IDX_DB_DATA, mmio_pkg::IDX_AL_DATA};

   always #5 ref_clk = ~ref_clk;

   mmio_ports DUT (.REF_CLK(ref_clk), .NRST(nrst), .MODE(mode),
      .HW_STANDBY(hw_sb), .SW_STANDBY(sw_sb), .WB_CYC(cyc), .WB_STB(stb),
      .WB_WE(we), .WB_SEL(sel), .WB_ADR(adr), .WB_DAT_I(dat_i),
      .WB_DAT_O(dat_o), .WB_ACK(ack), .WB_ERR(err), .BUS_STROBE(strobe),
      .BUS_DATA_OUT(dout), .BUS_DATA_DRIVE(drive), .BUS_ADDR_LOW(al),
      .BUS_DATA_IN(din), .CTL_PIN_IN(ctl_in), .CTL_PIN_OUT(ctl_out),
      .CTL_PIN_OE(ctl_oe), .DB_PIN_IN(db_in), .DB_PIN_OUT(db_out),
      .DB_PIN_OE(db_oe), .AL_PIN_IN(al_in), .AL_PIN_OUT(al_out),
      .AL_PIN_OE(al_oe));

   mmio_pins_model pins (.ctl_out(ctl_out), .ctl_oe(ctl_oe),
      .db_out(db_out), .db_oe(db_oe), .al_out(al_out), .al_oe(al_oe),
      .ext(ext), .ctl_in(ctl_in), .db_in(db_in), .al_in(al_in));

   // ****
   // helpers
   // ****
   task automatic end_of_test;
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t pins %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic expd();
      return mode >= 3'h1 && mode <= 3'h4;
   endfunction

   // single-chip view only: latch on outputs, far-side level on inputs
   function automatic logic [31:0] exp_rd(input int i);
      case (i)
         1: return {27'h7, (sh[1][4:0] & sh[0][4:0])
                    | (ext[20:16] & ~sh[0][4:0])};
         4: return {24'h0, (sh[4] & sh[2]) | (ext[15:8] & ~sh[2])};
         5: return {24'h0, (sh[5] & sh[3]) | (ext[7:0] & ~sh[3])};
         default: return 32'h000000FF;
      endcase
   endfunction

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d, input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      @(posedge ref_clk);
      while (ack !== 1'b1 && err !== 1'b1) begin
         @(posedge ref_clk);
      end
      rd = dat_o;
      rerr = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input int i, input logic [7:0] v, input logic [3:0] s);
      wb(1'b1, IDX[i], v, s);
      if (s[0] && !(expd() && (i == 0 || i == 3)))
         sh[i] = (i < 2) ? (v | 8'hE0) : v;
   endtask

   task automatic rst_sh;
      sh = '{8'hE0, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00};
   endtask

   task automatic dirs_out;
      wr(0, 8'hFF, 4'h1);
      wr(2, 8'hFF, 4'h1);
      wr(3, 8'hFF, 4'h1);
   endtask

   task automatic chk_all;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, IDX[i], 8'h00, 4'h1);
         chk_reg(rd, exp_rd(i));
         chk_reg({31'h0, rerr}, 32'h0);
      end
      chk_pin({3'h0, ctl_oe}, sh[0] & 8'h1F);
      chk_pin({3'h0, ctl_out & ctl_oe}, sh[1] & sh[0] & 8'h1F);
      chk_pin(db_oe, sh[2]);
      chk_pin(db_out & db_oe, sh[4] & sh[2]);
      chk_pin(al_oe, sh[3]);
      chk_pin(al_out & al_oe, sh[5] & sh[3]);
   endtask

   // ****
   // sequence
   // ****
   initial begin
      int i;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rst_sh();
      chk_all();
      dirs_out();
      chk_all();
      repeat (40) begin
         i = {$random(seed)} % 6;
         ext <= 21'($random(seed));
         wr(i, 8'($random(seed)), 4'($random(seed)));
         chk_all();
      end
      sw_sb <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chk_all();
      sw_sb <= 1'b0;
      for (int m = 0; m < 8; m++) begin
         mode <= 3'(m);
         strobe <= mmio_pkg::mmio_strobe_type'(5'($random(seed)));
         al <= 8'($random(seed));
         dout <= 8'($random(seed));
         drive <= m[0];
         @(posedge ref_clk);
         wr(0, ~sh[0], 4'h1);
         wr(3, ~sh[3], 4'h1);
         repeat (2) @(posedge ref_clk);
         wb(1'b0, mmio_pkg::IDX_MODE_STAT, 8'h00, 4'h1);
         chk_reg(rd, {24'h0, 4'h0, expd(), mode});
         if (m >= 1 && m <= 4) begin
            chk_pin({3'h0, ctl_oe}, 8'h1F);
            chk_pin({3'h0, ctl_out}, {3'h0, strobe});
            chk_pin(al_oe, 8'hFF);
            chk_pin(al_out, al);
            chk_pin(db_oe, {8{drive}});
            chk_pin(db_out & db_oe, dout & db_oe);
            chk_pin(din, drive ? dout : ext[15:8]);
            mode <= 3'h7;
            repeat (2) @(posedge ref_clk);
         end
         chk_all();
      end
      hw_sb <= 1'b1;
      repeat (3) @(posedge ref_clk);
      hw_sb <= 1'b0;
      @(posedge ref_clk);
      rst_sh();
      chk_all();
      dirs_out();
      chk_all();
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rst_sh();
      chk_all();
      wb(1'b0, 16'hFF89, 8'h00, 4'h1);
      chk_reg({31'h0, rerr}, 32'h1);
      end_of_test();
   end

   // whole run is about 1240 cycles; this is some sixteen times that
   initial begin
      #200000;
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_of_test();
   end
endmodule
